// file: hw/scx_pkg.sv
// constants and types for the subroutine call execution block
package scx_pkg;
  localparam int          PC_W        = 16;
  localparam int          LIT_W       = 13;
  localparam int          INSN_W      = 16;
  localparam int          LATCH_W     = 8;
  localparam logic [2:0]  CALL_OPCODE = 3'h7;
  localparam int          OPC_HI      = 15;
  localparam int          OPC_LO      = 13;
  localparam int          LIT_HI      = 12;
  localparam int          LIT_MID     = 8;
  localparam int          LAT_PAGE_LO = 5;
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [7:0]  LATCH_RESET = 8'h00;
  localparam logic [15:0] PC_ONE      = 16'h0001;
  localparam int          CALL_CYCLES = 2;

  // four internal phases of one instruction cycle
  typedef enum logic [1:0] {
    SCX_Q1,
    SCX_Q2,
    SCX_Q3,
    SCX_Q4
  } scx_phase_t;
endpackage

// file: hw/scx_phase_if.sv
// phase and stage signals shared between the call executor and its sequencer
`timescale 1ns/1ns
`default_nettype none
interface scx_phase_if;
  scx_pkg::scx_phase_t phase;
  logic                q4_end;
  modport seq (output phase, output q4_end);
  modport use_side (input phase, input q4_end);
endinterface
`default_nettype wire

// file: hw/scx_phase_seq.sv
// four-phase sequencer inside one instruction cycle
`timescale 1ns/1ns
`default_nettype none
module scx_phase_seq (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // phase outputs
  scx_phase_if.seq  ph
);
  scx_pkg::scx_phase_t phase;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      phase <= scx_pkg::SCX_Q1;
    end else begin
      unique case (phase)
        scx_pkg::SCX_Q1: phase <= scx_pkg::SCX_Q2;
        scx_pkg::SCX_Q2: phase <= scx_pkg::SCX_Q3;
        scx_pkg::SCX_Q3: phase <= scx_pkg::SCX_Q4;
        scx_pkg::SCX_Q4: phase <= scx_pkg::SCX_Q1;
      endcase
    end
  end

  assign ph.phase  = phase;
  assign ph.q4_end = (phase == scx_pkg::SCX_Q4);
endmodule // scx_phase_seq
`default_nettype wire

// file: hw/scx_call_exec.sv
// decode and execution of the short subroutine call instruction
// Operation
// [RULE1] A word whose top three bits are 111 is a call and its low thirteen bits are the target.
// [RULE2] The target is an unsigned 13-bit value from 0 to 8191, one 8K page.
// [RULE3] The call first pushes the return address, counter plus one, onto the stack top.
// [RULE4] The literal is loaded into counter bits 12 to 0.
// [RULE5] The high latch then takes literal bits 12..8 in bits 4..0 and counter bits 15..13 in 7..5.
// [RULE6] The call leaves every arithmetic status flag unchanged.
// [RULE7] The call is one word long and takes two instruction cycles.
// [RULE8] First cycle: decode in Q1, read low literal and push in Q2, process in Q3, write PC in Q4. The push is requested in Q2 but push_en is seen in Q3.
// [RULE9] Targets outside the current 8K page should use the far subroutine jump instead.
// [RULE10] The second cycle does nothing in all phases and discards the prefetched word.
// [RULE11] Counter bits 15 to 13 are not changed by the call.
`timescale 1ns/1ns
`default_nettype none
module scx_call_exec #(
  parameter int PC_W    = scx_pkg::PC_W,
  parameter int LATCH_W = scx_pkg::LATCH_W
) (
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       srst,
  // fetched instruction word, valid for the cycle starting at Q1
  input  wire logic [scx_pkg::INSN_W-1:0] insn_word,
  // status flags from the alu, passed through untouched
  input  wire logic [7:0]                 status_in,
  output logic      [7:0]                 status_out,
  // program counter and latch
  output logic      [PC_W-1:0]            pc,
  output logic      [LATCH_W-1:0]         pc_high_latch,
  // stack push port
  output logic                            push_en,
  output logic      [PC_W-1:0]            stack_top_entry,
  // fetch control and status
  output logic                            flush_fetch,
  output logic      [3:0]                 phase_onehot,
  output logic                            call_busy,
  output logic                            is_call,
  output logic      [scx_pkg::LIT_W-1:0]  call_literal
);
  scx_phase_if ph ();

  scx_phase_seq u_seq (
    .core_clk (core_clk),
    .srst     (srst),
    .ph       (ph)
  );

  // field split of the fetched word
  logic [scx_pkg::OPC_HI-scx_pkg::OPC_LO:0] opc_field;
  logic [scx_pkg::LIT_W-1:0]                lit_field;
  logic                                     decoded_call;
  // first-cycle phase strobes
  logic                                     q1_take;
  logic                                     q2_act;
  logic                                     q3_act;
  logic                                     q4_act;
  // call state
  logic                                     in_call;
  logic                                     in_dead;
  logic                                     next_dead;
  logic [scx_pkg::LIT_W-1:0]                lit;
  logic [scx_pkg::LIT_MID-1:0]              lit_lo;
  // counter path
  logic [PC_W-1:0]                          work_pc;
  logic [PC_W-1:0]                          next_pc;
  logic [PC_W-1:0]                          ret_addr;
  logic [PC_W-scx_pkg::LIT_W-1:0]           page_bits;
  logic [LATCH_W-1:0]                       next_latch;
  logic [PC_W-1:0]                          next_stack_top;
  logic                                     next_push;

  assign opc_field = insn_word[scx_pkg::OPC_HI:scx_pkg::OPC_LO];
  assign lit_field = insn_word[scx_pkg::LIT_W-1:0];
  // opcode match is combinational off the fetched word
  assign decoded_call = (opc_field == scx_pkg::CALL_OPCODE); // [RULE1]

  // the word prefetched during the dead cycle is never decoded
  assign q1_take = (ph.phase == scx_pkg::SCX_Q1) && !in_dead; // [RULE10]
  assign q2_act  = in_call && (ph.phase == scx_pkg::SCX_Q2);
  assign q3_act  = in_call && (ph.phase == scx_pkg::SCX_Q3);
  assign q4_act  = in_call && ph.q4_end;

  // page bits come from the running counter, never from the word
  assign page_bits = pc[PC_W-1:scx_pkg::LIT_W]; // [RULE11]
  // wraps at the top of memory, like the counter itself
  assign ret_addr  = pc + PC_W'(scx_pkg::PC_ONE); // [RULE3]

  // literal held from decode so a word change later in the cycle is harmless
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lit <= '0;
    end else if (q1_take) begin
      lit <= lit_field; // [RULE1] [RULE2]
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      in_call <= 1'b0;
    end else if (q1_take) begin
      in_call <= decoded_call; // [RULE1]
    end else if (ph.q4_end) begin
      in_call <= 1'b0;
    end
  end

  // dead cycle follows the first cycle only; a call cannot chain into itself
  always_comb begin
    next_dead = in_dead;
    if (ph.q4_end) begin
      next_dead = in_call && !in_dead; // [RULE7] [RULE10]
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      in_dead <= 1'b0;
    end else begin
      in_dead <= next_dead;
    end
  end

  // low literal byte read in Q2
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lit_lo <= '0;
    end else if (q2_act) begin
      lit_lo <= lit[scx_pkg::LIT_MID-1:0]; // [RULE8]
    end
  end

  // push request and return address for the stack top
  always_comb begin
    next_push      = q2_act; // [RULE3] [RULE8]
    next_stack_top = stack_top_entry;
    if (q2_act) begin
      next_stack_top = ret_addr; // [RULE3]
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      push_en <= 1'b0;
    end else begin
      push_en <= next_push;
    end
  end

  // entry is held after the pulse so the stack may take it late
  always_ff @(posedge core_clk) begin
    if (srst) begin
      stack_top_entry <= '0;
    end else begin
      stack_top_entry <= next_stack_top;
    end
  end

  // process data in Q3: form the target, page bits kept
  always_ff @(posedge core_clk) begin
    if (srst) begin
      work_pc <= scx_pkg::PC_RESET;
    end else if (q3_act) begin
      work_pc <= {page_bits, lit[scx_pkg::LIT_HI:scx_pkg::LIT_MID], lit_lo}; // [RULE4] [RULE11]
    end
  end

  // counter advances by one per ordinary cycle, jumps on the call's Q4
  always_comb begin
    next_pc = pc;
    if (ph.q4_end) begin
      if (in_call) begin
        next_pc = work_pc; // [RULE4] [RULE8]
      end else if (!in_dead) begin
        next_pc = pc + PC_W'(scx_pkg::PC_ONE);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pc <= scx_pkg::PC_RESET;
    end else begin
      pc <= next_pc;
    end
  end

  // latch update on the same Q4 edge as the counter write, page bits taken from the old counter
  always_comb begin
    next_latch = pc_high_latch;
    if (q4_act) begin
      next_latch = {page_bits, lit[scx_pkg::LIT_HI:scx_pkg::LIT_MID]}; // [RULE5] [RULE11]
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pc_high_latch <= scx_pkg::LATCH_RESET;
    end else begin
      pc_high_latch <= next_latch;
    end
  end

  // flags are never written by this path
  always_ff @(posedge core_clk) begin
    if (srst) begin
      status_out <= '0;
    end else begin
      status_out <= status_in; // [RULE6]
    end
  end

  // prefetched word during the dead cycle is thrown away
  assign flush_fetch  = in_dead; // [RULE10]
  assign call_busy    = in_call || in_dead;
  assign is_call      = in_call;
  assign call_literal = lit;

  // one decode per phase bit
  genvar gi;
  generate
    for (gi = 0; gi < $bits(phase_onehot); gi++) begin : g_onehot
      assign phase_onehot[gi] = (ph.phase == scx_pkg::scx_phase_t'(gi));
    end
  endgenerate
endmodule // scx_call_exec
`default_nettype wire

// file: verif/scx_call_exec_assertions.sv
// checker for the subroutine call executor
`timescale 1ns/1ns
`default_nettype none
module scx_call_exec_assertions #(
  parameter int PC_W    = 16,
  parameter int LATCH_W = 8
) (
  // clock and reset
  input wire logic               core_clk,
  input wire logic               srst,
  // watched ports
  input wire logic [15:0]        insn_word,
  input wire logic [7:0]         status_in,
  input wire logic [7:0]         status_out,
  input wire logic [PC_W-1:0]    pc,
  input wire logic [LATCH_W-1:0] pc_high_latch,
  input wire logic               push_en,
  input wire logic [PC_W-1:0]    stack_top_entry,
  input wire logic               flush_fetch,
  input wire logic [3:0]         phase_onehot,
  input wire logic               call_busy,
  input wire logic               is_call,
  input wire logic [12:0]        call_literal
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence take;
    phase_onehot[0] && !flush_fetch && insn_word[15:13] == 3'h7;
  endsequence
  AST_DECODE: assert property (take |=> is_call && call_literal == $past(insn_word[12:0]))
    else $error("call not decoded");
  AST_PUSH: assert property (take |-> ##2 push_en && stack_top_entry == $past(pc, 2) + 16'h0001)
    else $error("bad push");
  AST_PC_LOW: assert property (take |-> ##4 pc[12:0] == $past(insn_word[12:0], 4))
    else $error("bad target");
  AST_PAGE: assert property (take |-> ##4 pc[15:13] == $past(pc[15:13], 4))
    else $error("page changed");
  AST_LATCH: assert property (take |-> ##4 pc_high_latch == {pc[15:13], $past(insn_word[12:8], 4)})
    else $error("bad latch");
  AST_DEAD: assert property (take |-> ##4 flush_fetch [*4] ##1 !flush_fetch)
    else $error("bad dead cycle");
  AST_Q3_PUSH: assert property (push_en |-> call_busy && phase_onehot[2])
    else $error("push outside q3");
  AST_FLAGS: assert property (!$past(srst) |-> status_out == $past(status_in))
    else $error("flags changed");
  AST_STEP: assert property (phase_onehot[3] && !call_busy |=> pc == $past(pc) + 16'h0001)
    else $error("pc not stepped");
endmodule // scx_call_exec_assertions
bind scx_call_exec scx_call_exec_assertions #(.PC_W(PC_W), .LATCH_W(LATCH_W)) u_chk (
  .core_clk(core_clk), .srst(srst), .insn_word(insn_word), .status_in(status_in),
  .status_out(status_out), .pc(pc), .pc_high_latch(pc_high_latch), .push_en(push_en),
  .stack_top_entry(stack_top_entry), .flush_fetch(flush_fetch), .phase_onehot(phase_onehot),
  .call_busy(call_busy), .is_call(is_call), .call_literal(call_literal));
`default_nettype wire

// file: verif/tb_subroutine_call_execution.sv
// testbench for the subroutine call executor
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module tb_subroutine_call_execution;
  logic core_clk = 0, srst = 1, push_en, flush_fetch, call_busy, is_call;
  logic [15:0] insn_word = 16'hdfff, pc, stack_top_entry, epc;
  logic [7:0] status_in = 8'h00, status_out, pc_high_latch;
  logic [3:0] phase_onehot;
  logic [12:0] call_literal;
  int n_errors = 0, compares = 0;
  always #5 core_clk = ~core_clk;
  scx_call_exec DUT (.core_clk(core_clk), .srst(srst), .insn_word(insn_word),
    .status_in(status_in), .status_out(status_out), .pc(pc), .pc_high_latch(pc_high_latch),
    .push_en(push_en), .stack_top_entry(stack_top_entry), .flush_fetch(flush_fetch),
    .phase_onehot(phase_onehot), .call_busy(call_busy), .is_call(is_call),
    .call_literal(call_literal));
  task automatic end_of_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // 110 in the top bits must not decode as a call
  task automatic plain(input int n);
    repeat (n) begin
      insn_word = 16'hdfff;
      repeat (4) @(negedge core_clk);
      epc++;
      `CHK(pc, epc)
    end
  endtask
  task automatic call_after(input int n, input logic [15:0] w);
    srst = 1;
    repeat (2) @(negedge core_clk);
    srst = 0;
    epc = 16'h0000;
    plain(n);
    insn_word = w;
    status_in = w[7:0];
    @(negedge core_clk);
    `CHK(is_call, 1'b1)
    `CHK(call_busy, 1'b1)
    `CHK(phase_onehot, 4'h2)
    `CHK(call_literal, w[12:0])
    `CHK(status_out, w[7:0])
    @(negedge core_clk);
    `CHK(push_en, 1'b1)
    `CHK(stack_top_entry, epc + 16'h0001)
    @(negedge core_clk);
    `CHK(push_en, 1'b0)
    @(negedge core_clk);
    `CHK(pc, {epc[15:13], w[12:0]})
    `CHK(pc_high_latch, {epc[15:13], w[12:8]})
    `CHK(flush_fetch, 1'b1)
    `CHK(call_busy, 1'b1)
    // a call word in the dead cycle must be dropped
    insn_word = 16'he000;
    repeat (4) @(negedge core_clk);
    `CHK(flush_fetch, 1'b0)
    `CHK(call_busy, 1'b0)
    `CHK(is_call, 1'b0)
    `CHK(pc, {epc[15:13], w[12:0]})
    `CHK(pc_high_latch, {epc[15:13], w[12:8]})
  endtask
  initial begin
    call_after(3, 16'he123);
    call_after(0, 16'he000);
    // page 1 start, top target: page bits must survive
    call_after(8192, 16'hffff);
    end_of_test();
  end
  initial begin
    #500000;
    n_errors++;
    end_of_test();
  end
endmodule // tb_subroutine_call_execution
`default_nettype wire
